// ### hdl/isp_pkg.sv
package isp_pkg;
  localparam int unsigned CLK_FREQ_HZ       = 200000000;
  localparam int unsigned FLASH_WAIT_US     = 4500;
  localparam int unsigned EEPROM_WAIT_US    = 3600;
  localparam int unsigned ERASE_WAIT_US     = 9000;
  localparam int unsigned FLASH_WAIT_CYC    = FLASH_WAIT_US * (CLK_FREQ_HZ / 1000000);
  localparam int unsigned EEPROM_WAIT_CYC   = EEPROM_WAIT_US * (CLK_FREQ_HZ / 1000000);
  localparam int unsigned ERASE_WAIT_CYC    = ERASE_WAIT_US * (CLK_FREQ_HZ / 1000000);

  localparam logic [7:0] OP_ENABLE          = 8'hac;
  localparam logic [7:0] SUB_ENABLE         = 8'h53;
  localparam logic [7:0] SUB_ERASE          = 8'h80;
  localparam logic [7:0] SUB_WR_LOCK        = 8'he0;
  localparam logic [7:0] SUB_WR_FUSE_LO     = 8'ha0;
  localparam logic [7:0] SUB_WR_FUSE_HI     = 8'ha8;
  localparam logic [7:0] SUB_WR_FUSE_EXT    = 8'ha4;
  localparam logic [7:0] OP_POLL            = 8'hf0;
  localparam logic [7:0] OP_LD_EXT          = 8'h4d;
  localparam logic [7:0] OP_LD_HI           = 8'h48;
  localparam logic [7:0] OP_LD_LO           = 8'h40;
  localparam logic [7:0] OP_LD_EE_PAGE      = 8'hc1;
  localparam logic [7:0] OP_RD_HI           = 8'h28;
  localparam logic [7:0] OP_RD_LO           = 8'h20;
  localparam logic [7:0] OP_RD_EE           = 8'ha0;
  localparam logic [7:0] OP_RD_LOCK_FHI     = 8'h58;
  localparam logic [7:0] OP_RD_FUSE_FEXT    = 8'h50;
  localparam logic [7:0] OP_RD_SIG          = 8'h30;
  localparam logic [7:0] OP_RD_CAL          = 8'h38;
  localparam logic [7:0] OP_WR_PAGE         = 8'h4c;
  localparam logic [7:0] OP_WR_EE           = 8'hc0;
  localparam logic [7:0] OP_WR_EE_PAGE      = 8'hc2;
  localparam logic [7:0] SUB_FUSE_ALT       = 8'h08;

  localparam logic [7:0] ERASED_BYTE        = 8'hff;
  localparam int unsigned FLASH_PAGE_WORDS  = 128;
  localparam int unsigned EE_PAGE_BYTES     = 4;
  localparam int unsigned EE_ADDR_W         = 10;
  localparam int unsigned WADDR_W           = 24;
  localparam int unsigned SYNC_STAGES       = 3;
  localparam logic [7:0] SIG_DEFAULT        = 8'h5a;
  localparam logic [7:0] CAL_DEFAULT        = 8'h80;
endpackage

// ### hdl/isp_sync.sv
`timescale 1ns/1ps
module isp_sync
  import isp_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic din,
  output logic      dout,
  output logic      rise,
  output logic      fall
);
  logic [SYNC_STAGES-1:0] sh_r;
  logic                   level_r;

  // stage 0 only feeds stage 1; change counted when stages 1 and 2 agree
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sh_r    <= '0;
      level_r <= 1'b0;
    end else begin
      sh_r <= {sh_r[SYNC_STAGES-2:0], din};
      if (sh_r[1] == sh_r[2]) begin
        level_r <= sh_r[2];
      end
    end
  end

  assign dout = level_r;
  assign rise = (sh_r[1] == sh_r[2]) && sh_r[2] && !level_r;
  assign fall = (sh_r[1] == sh_r[2]) && !sh_r[2] && level_r;
endmodule // isp_sync

// ### hdl/isp_prog.sv
// Operation
// - programming only accepted while device reset pin is low
// - program and erase refused until enable instruction executed
// - eeprom writes erase the location inside their timed cycle
// - chip erase sets flash and eeprom to all ones
// - sample input on rising serial clock, shift output on falling
// - echo second enable byte during third byte when in sync
// - every instruction is four bytes; enable is ac 53 00 00
// - flash page loaded bytewise, low byte opcode 40, high 48
// - extended address byte kept until reissued
// - opcode 4c commits page buffer to flash at word address
// - poll opcode f0 returns busy in bit zero of byte four
// - opcode c0 writes byte four to ten-bit eeprom address
// - c1 loads eeprom page buffer, c2 commits page
// - reads return addressed byte during byte four
// - lock, fuse, signature and calibration reads by opcode
// - ac e0/a0/a8/a4 write lock and fuse bytes from byte four
`timescale 1ns/1ps
module isp_prog
  import isp_pkg::*;
#(
  parameter int unsigned FLASH_CYC  = FLASH_WAIT_CYC,
  parameter int unsigned EEPROM_CYC = EEPROM_WAIT_CYC,
  parameter int unsigned ERASE_CYC  = ERASE_WAIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        dev_reset_pin,
  input  wire logic        sck,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe,
  output logic             prog_enabled,
  output logic             operation_pending_flag,
  output logic [7:0]       lock_bits,
  output logic [7:0]       fuse_low,
  output logic [7:0]       fuse_high,
  output logic [7:0]       fuse_ext
);
  typedef enum logic [1:0] {
    ISP_IDLE  = 2'b00,
    ISP_FLASH = 2'b01,
    ISP_EE    = 2'b10,
    ISP_ERASE = 2'b11
  } isp_busy_e;

  logic sck_rise, sck_fall, mosi_lvl, rst_lvl;

  // sck level itself unused; only its edges drive the shifters
  isp_sync u_sck (.clk(clk), .reset_n(reset_n), .din(sck), .dout(),
                  .rise(sck_rise), .fall(sck_fall));
  isp_sync u_mosi (.clk(clk), .reset_n(reset_n), .din(mosi), .dout(mosi_lvl),
                   .rise(), .fall());
  isp_sync u_rst (.clk(clk), .reset_n(reset_n), .din(dev_reset_pin), .dout(rst_lvl),
                  .rise(), .fall());

  wire active = !rst_lvl;

  logic [7:0]  shin_r, shout_r, b1_r, b2_r, b3_r;
  logic [2:0]  bit_r;
  logic [1:0]  byte_r;
  logic        en_r;
  logic [7:0]  ext_r;
  isp_busy_e   busy_r;
  logic [31:0] wait_r;
  logic [7:0]  flash_lo [0:FLASH_PAGE_WORDS-1];
  logic [7:0]  flash_hi [0:FLASH_PAGE_WORDS-1];
  logic [7:0]  ee_buf   [0:EE_PAGE_BYTES-1];
  logic [7:0]  ee_mem   [0:(1<<EE_ADDR_W)-1];
  // flash array modelled as a small window of 256 words; wider arrays are not modelled
  logic [7:0]  fl_mem_lo [0:255];
  logic [7:0]  fl_mem_hi [0:255];
  logic [7:0]  lock_r, flo_r, fhi_r, fext_r;

  wire [7:0] byte_in = {shin_r[6:0], mosi_lvl};
  wire       byte_done = active && sck_rise && (bit_r == 3'd7);
  wire       instr_done = byte_done && (byte_r == 2'd3);
  wire       can_write = en_r && (busy_r == ISP_IDLE);
  wire [7:0] fl_a = b3_r; // word address bit 7 picks the page
  wire [EE_ADDR_W-1:0] ee_a = {b2_r[1:0], b3_r};

  // bit and byte counters, msb first
  always_ff @(posedge clk) begin
    if (!reset_n || !active) begin
      shin_r <= '0;
      bit_r  <= '0;
      byte_r <= '0;
      b1_r   <= '0;
      b2_r   <= '0;
      b3_r   <= '0;
    end else if (sck_rise) begin
      shin_r <= byte_in;
      bit_r  <= bit_r + 3'd1;
      if (bit_r == 3'd7) begin
        byte_r <= byte_r + 2'd1;
        case (byte_r)
          2'd0:    b1_r <= byte_in;
          2'd1:    b2_r <= byte_in;
          2'd2:    b3_r <= byte_in;
          default: ;
        endcase
      end
    end
  end

  // reply byte for the next slot
  function automatic logic [7:0] reply(input logic [1:0] slot, input logic [7:0] nb);
    logic [7:0] r;
    r = 8'h00;
    if (slot == 2'd1 && b1_r == OP_ENABLE) begin
      r = nb;
    end else if (slot == 2'd2) begin
      case (b1_r)
        OP_POLL:         r = {7'h00, busy_r != ISP_IDLE};
        OP_RD_HI:        r = fl_mem_hi[nb];
        OP_RD_LO:        r = fl_mem_lo[nb];
        OP_RD_EE:        r = ee_mem[{b2_r[1:0], nb}];
        OP_RD_LOCK_FHI:  r = (b2_r == SUB_FUSE_ALT) ? fhi_r : lock_r;
        OP_RD_FUSE_FEXT: r = (b2_r == SUB_FUSE_ALT) ? fext_r : flo_r;
        OP_RD_SIG:       r = SIG_DEFAULT ^ {6'h00, nb[1:0]}; // arbitrary signature value
        OP_RD_CAL:       r = CAL_DEFAULT;
        default:         r = 8'h00;
      endcase
    end
    return r;
  endfunction

  always_ff @(posedge clk) begin
    if (!reset_n || !active) begin
      shout_r <= '0;
    end else if (byte_done) begin
      shout_r <= reply(byte_r, byte_in);
    end else if (sck_fall && bit_r != 3'd0) begin
      shout_r <= {shout_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      miso    <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso    <= shout_r[7];
      miso_oe <= active;
    end
  end

  // enable handshake and extended address
  always_ff @(posedge clk) begin
    if (!reset_n || !active) begin
      en_r  <= 1'b0;
      ext_r <= '0;
    end else if (instr_done) begin
      if (b1_r == OP_ENABLE && b2_r == SUB_ENABLE) begin
        en_r <= 1'b1;
      end
      if (b1_r == OP_LD_EXT && en_r) begin
        ext_r <= b3_r;
      end
    end
  end

  // busy timer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_r <= ISP_IDLE;
      wait_r <= '0;
    end else if (busy_r != ISP_IDLE) begin
      if (wait_r <= 32'd1) begin
        busy_r <= ISP_IDLE;
      end
      wait_r <= wait_r - 32'd1;
    end else if (instr_done && can_write) begin
      if (b1_r == OP_WR_PAGE) begin
        busy_r <= ISP_FLASH;
        wait_r <= FLASH_CYC;
      end else if (b1_r == OP_WR_EE || b1_r == OP_WR_EE_PAGE) begin
        busy_r <= ISP_EE;
        wait_r <= EEPROM_CYC;
      end else if (b1_r == OP_ENABLE && b2_r == SUB_ERASE) begin
        busy_r <= ISP_ERASE;
        wait_r <= ERASE_CYC;
      end else if (b1_r == OP_ENABLE && b2_r != SUB_ENABLE) begin
        busy_r <= ISP_EE;
        wait_r <= EEPROM_CYC;
      end
    end
  end

  // page buffers
  always_ff @(posedge clk) begin
    if (instr_done && en_r) begin
      if (b1_r == OP_LD_LO) flash_lo[b3_r[6:0]] <= byte_in;
      if (b1_r == OP_LD_HI) flash_hi[b3_r[6:0]] <= byte_in;
      if (b1_r == OP_LD_EE_PAGE) ee_buf[b3_r[1:0]] <= byte_in;
    end
  end

  // memory arrays; erase walks every entry in one cycle
  // modelled flash window sits at extended address zero
  genvar gi;
  generate
    for (gi = 0; gi < 1024; gi++) begin : g_ee
      always_ff @(posedge clk) begin
        if (instr_done && can_write) begin
          if (b1_r == OP_ENABLE && b2_r == SUB_ERASE) begin
            ee_mem[gi] <= ERASED_BYTE;
          end else if (b1_r == OP_WR_EE && ee_a == EE_ADDR_W'(gi)) begin
            ee_mem[gi] <= byte_in;
          end else if (b1_r == OP_WR_EE_PAGE && ee_a[9:2] == 8'(gi / EE_PAGE_BYTES)) begin
            ee_mem[gi] <= ee_buf[gi % EE_PAGE_BYTES];
          end
        end
      end
    end
    for (gi = 0; gi < 256; gi++) begin : g_fl
      always_ff @(posedge clk) begin
        if (instr_done && can_write) begin
          if (b1_r == OP_ENABLE && b2_r == SUB_ERASE) begin
            fl_mem_lo[gi] <= ERASED_BYTE;
            fl_mem_hi[gi] <= ERASED_BYTE;
          end else if (b1_r == OP_WR_PAGE && ext_r == 8'h00 &&
                       fl_a[7] == 1'(gi / FLASH_PAGE_WORDS)) begin
            fl_mem_lo[gi] <= flash_lo[gi % FLASH_PAGE_WORDS];
            fl_mem_hi[gi] <= flash_hi[gi % FLASH_PAGE_WORDS];
          end
        end
      end
    end
  endgenerate

  // lock and fuse bytes; chip erase clears lock only
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lock_r <= ERASED_BYTE;
      flo_r  <= ERASED_BYTE;
      fhi_r  <= ERASED_BYTE;
      fext_r <= ERASED_BYTE;
    end else if (instr_done && can_write && b1_r == OP_ENABLE) begin
      case (b2_r)
        SUB_ERASE:       lock_r <= ERASED_BYTE;
        SUB_WR_LOCK:     lock_r <= byte_in;
        SUB_WR_FUSE_LO:  flo_r  <= byte_in;
        SUB_WR_FUSE_HI:  fhi_r  <= byte_in;
        SUB_WR_FUSE_EXT: fext_r <= byte_in;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prog_enabled           <= 1'b0;
      operation_pending_flag <= 1'b0;
      lock_bits              <= ERASED_BYTE;
      fuse_low               <= ERASED_BYTE;
      fuse_high              <= ERASED_BYTE;
      fuse_ext               <= ERASED_BYTE;
    end else begin
      prog_enabled           <= en_r;
      operation_pending_flag <= busy_r != ISP_IDLE;
      lock_bits              <= lock_r;
      fuse_low               <= flo_r;
      fuse_high              <= fhi_r;
      fuse_ext               <= fext_r;
    end
  end

  a_refuse_unenabled: assert property (@(posedge clk) disable iff (!reset_n)
    (busy_r == ISP_IDLE && !en_r) |=> busy_r == ISP_IDLE)
    else $error("write started without enable");
  a_busy_reports: assert property (@(posedge clk) disable iff (!reset_n)
    (busy_r != ISP_IDLE) |-> ##1 operation_pending_flag)
    else $error("busy not reported");
  a_reset_drops: assert property (@(posedge clk) disable iff (!reset_n)
    rst_lvl |=> !en_r && !miso_oe ##0 byte_r == 2'd0)
    else $error("session kept with reset high");

  // steps of the enable echo, the poll reply and the erase commit
  sequence s_enable_second;
    byte_done && byte_r == 2'd1 && b1_r == OP_ENABLE && byte_in == SUB_ENABLE;
  endsequence
  sequence s_poll_third;
    byte_done && byte_r == 2'd2 && b1_r == OP_POLL;
  endsequence
  sequence s_erase_commit;
    instr_done && can_write && b1_r == OP_ENABLE && b2_r == SUB_ERASE;
  endsequence

  a_enable_echo: assert property (@(posedge clk) disable iff (!reset_n)
    s_enable_second |=> shout_r == SUB_ENABLE ##1 miso == SUB_ENABLE[7])
    else $error("enable byte not echoed");
  a_poll_reply: assert property (@(posedge clk) disable iff (!reset_n)
    s_poll_third |=> shout_r[7:1] == 7'h00 && shout_r[0] == ($past(busy_r) != ISP_IDLE))
    else $error("poll reply wrong");
  a_erase_fills: assert property (@(posedge clk) disable iff (!reset_n)
    s_erase_commit |=> ee_mem[0] == ERASED_BYTE && fl_mem_lo[255] == ERASED_BYTE
      && busy_r == ISP_ERASE)
    else $error("erase left data");
  a_ext_kept: assert property (@(posedge clk) disable iff (!reset_n)
    (active && !(instr_done && b1_r == OP_LD_EXT)) |=> $stable(ext_r))
    else $error("extended address lost");
endmodule // isp_prog

// ### testbench/isp_master.sv
`timescale 1ns/1ps
module isp_master (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [31:0] tx,
  input  wire logic        miso,
  output logic [31:0]      rx,
  output logic             busy,
  output logic             sck,
  output logic             mosi
);
  initial begin
    sck  = 1'b0;
    mosi = 1'b0;
    busy = 1'b0;
    rx   = 32'h0;
    forever begin
      @(posedge clk);
      if (go === 1'b1) begin
        busy <= 1'b1;
        for (int i = 31; i >= 0; i--) begin
          mosi <= tx[i];
          repeat (13) @(posedge clk);
          sck   <= 1'b1;
          rx[i] <= miso;
          repeat (12) @(posedge clk);
          sck <= 1'b0;
        end
        // released line shows the inverse, not a stale value
        mosi <= ~tx[0];
        busy <= 1'b0;
      end
    end
  end
endmodule // isp_master

// ### testbench/isp_prog_tb.sv
`timescale 1ns/1ps
module isp_prog_tb import isp_pkg::*;
;
  logic        clk;
  logic        reset_n;
  logic        dev_reset_pin;
  logic        go;
  logic [31:0] tx;
  logic [31:0] r;
  logic        busy;
  logic        sck;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  logic        prog_enabled;
  logic        operation_pending_flag;
  logic [7:0]  lock_bits;
  logic [7:0]  fuse_low;
  logic [7:0]  fuse_high;
  logic [7:0]  fuse_ext;
  logic [31:0] fuse_all;
  int          n_errors;
  int          checks_done;
  logic [7:0]  wsub [4];
  logic [15:0] rdop [4];
  logic [7:0]  v;

  assign fuse_all = {fuse_ext, fuse_high, fuse_low, lock_bits};

  // long waits shortened so a poll frame still sees the busy bit
  isp_prog #(.FLASH_CYC(1000), .EEPROM_CYC(1000), .ERASE_CYC(1000)) DUT (
    .clk(clk), .reset_n(reset_n), .dev_reset_pin(dev_reset_pin), .sck(sck), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .prog_enabled(prog_enabled),
    .operation_pending_flag(operation_pending_flag), .lock_bits(lock_bits),
    .fuse_low(fuse_low), .fuse_high(fuse_high), .fuse_ext(fuse_ext)
  );

  isp_master PGM (
    .clk(clk), .go(go), .tx(tx), .miso(miso), .rx(r), .busy(busy), .sck(sck), .mosi(mosi)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic xfer(input logic [31:0] t);
    int n;
    tx <= t;
    go <= 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 5) begin
      @(posedge clk);
      n++;
    end
    go <= 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 900) begin
      @(posedge clk);
      n++;
    end
    cmp1(busy, 1'b0, "frame end");
    repeat (2) @(posedge clk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (operation_pending_flag !== 1'b0 && n < 1100) begin
      @(posedge clk);
      n++;
    end
    cmp1(operation_pending_flag, 1'b0, "busy clears");
  endtask

  initial begin
    #400000;
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    reset_n       = 1'b0;
    dev_reset_pin = 1'b1;
    go            = 1'b0;
    tx            = 32'h0;
    n_errors      = 0;
    checks_done   = 0;
    wsub = '{SUB_WR_LOCK, SUB_WR_FUSE_LO, SUB_WR_FUSE_HI, SUB_WR_FUSE_EXT};
    rdop = '{{OP_RD_LOCK_FHI, 8'h00}, {OP_RD_FUSE_FEXT, 8'h00},
             {OP_RD_LOCK_FHI, SUB_FUSE_ALT}, {OP_RD_FUSE_FEXT, SUB_FUSE_ALT}};
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    dev_reset_pin <= 1'b0;
    repeat (50) @(posedge clk);
    cmp1(miso_oe, 1'b1, "output enable");
    xfer({OP_ENABLE, SUB_WR_FUSE_LO, 8'h00, 8'h55});
    cmp8(fuse_low, ERASED_BYTE, "write before enable");
    cmp1(prog_enabled, 1'b0, "not enabled");
    $display("test refuse done");
    xfer({OP_ENABLE, SUB_ENABLE, 16'h0});
    cmp8(r[15:8], SUB_ENABLE, "enable echo");
    cmp1(prog_enabled, 1'b1, "enabled");
    $display("test enable done");
    for (int i = 0; i < 4; i++) begin
      v = 8'hf0 + 8'(i);
      xfer({OP_ENABLE, wsub[i], 8'h00, v});
      cmp1(operation_pending_flag, 1'b1, "fuse busy");
      wait_idle();
      cmp8(fuse_all[8*i +: 8], v, "fuse port");
      xfer({rdop[i], 16'h0});
      cmp8(r[7:0], v, "fuse read");
    end
    $display("test fuses done");
    xfer({OP_LD_EXT, 24'h0});
    for (int p = 0; p < 2; p++) begin
      xfer({OP_LD_LO, 8'h00, 8'h05, 8'ha1 + 8'(p)});
      xfer({OP_LD_HI, 8'h00, 8'h05, 8'hb2 + 8'(p)});
      xfer({OP_WR_PAGE, 8'h00, 8'(p * 128), 8'h00});
      xfer({OP_POLL, 24'h0});
      cmp1(r[0], 1'b1, "poll busy");
      wait_idle();
      xfer({OP_POLL, 24'h0});
      cmp1(r[0], 1'b0, "poll idle");
    end
    for (int p = 0; p < 2; p++) begin
      xfer({OP_RD_LO, 8'h00, 8'h05 + 8'(p * 128), 8'h00});
      cmp8(r[7:0], 8'ha1 + 8'(p), "flash low");
      xfer({OP_RD_HI, 8'h00, 8'h05 + 8'(p * 128), 8'h00});
      cmp8(r[7:0], 8'hb2 + 8'(p), "flash high");
    end
    $display("test flash done");
    for (int k = 0; k < 2; k++) begin
      v = (k == 0) ? 8'h3c : 8'hc3;
      xfer({OP_WR_EE, 8'h01, 8'h23, v});
      cmp1(operation_pending_flag, 1'b1, "eeprom busy");
      wait_idle();
      xfer({OP_RD_EE, 8'h01, 8'h23, 8'h00});
      cmp8(r[7:0], v, "eeprom byte");
    end
    xfer({OP_LD_EE_PAGE, 8'h00, 8'h02, 8'hc7});
    xfer({OP_WR_EE_PAGE, 8'h00, 8'h04, 8'h00});
    wait_idle();
    xfer({OP_RD_EE, 8'h00, 8'h06, 8'h00});
    cmp8(r[7:0], 8'hc7, "eeprom page");
    $display("test eeprom done");
    xfer({OP_ENABLE, SUB_ERASE, 16'h0});
    cmp1(operation_pending_flag, 1'b1, "erase busy");
    wait_idle();
    xfer({OP_RD_LO, 8'h00, 8'h05, 8'h00});
    cmp8(r[7:0], ERASED_BYTE, "erased flash");
    xfer({OP_RD_EE, 8'h01, 8'h23, 8'h00});
    cmp8(r[7:0], ERASED_BYTE, "erased eeprom");
    xfer({OP_RD_SIG, 8'h00, 8'h02, 8'h00});
    cmp8(r[7:0], SIG_DEFAULT ^ 8'h02, "signature");
    xfer({OP_RD_CAL, 24'h0});
    cmp8(r[7:0], CAL_DEFAULT, "calibration");
    $display("test erase and ids done");
    dev_reset_pin <= 1'b1;
    repeat (10) @(posedge clk);
    cmp1(prog_enabled, 1'b0, "pin high disables");
    cmp1(miso_oe, 1'b0, "pin high releases");
    xfer({OP_ENABLE, SUB_ERASE, 16'h0});
    cmp1(operation_pending_flag, 1'b0, "erase with pin high");
    $display("test pin release done");
    tally_and_finish();
  end
endmodule // isp_prog_tb
